// ---- design/quasi_bidir_port_set.sv ----
`timescale 1ns/1ps
`include "port_defines.svh"

// Functional notes
// - Thirty-six lines: four byte-wide ports and one nibble port.
// - Latch zero switches the pull-down on, pin driven low.
// - Latch one releases the pull-down; pull-up lifts pin, not port zero.
// - Reset loads every latch bit with one.
// - Write strobe captures bus data; latch read returns latch.
// - Each port reads either its latch or its sampled pins.
// - Port zero as plain I/O is open drain, floating when high.
// - Port zero active pull-up only on bus with external access.
// - Port zero bus input forces its latches to one.
// - Output stages pick latch or bus: low address/data, high byte.
// - During bus use port zero and two latches are cut off; port zero latch all ones.
// - High address latch keeps its contents during bus use.
module quasi_bidir_port_set
	import port_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire core_req_type req,
	input  wire ext_bus_type  bus,
	input  wire logic         external_access_select,
	input  wire port_vec_type pin_in,
	output port_vec_type      pin_out_q,
	output port_vec_type      pin_oe_n_q,
	output logic              addr_data_pullup_q,
	output logic [7:0]        rd_data_q,
	output logic              rd_valid_q,
	output logic [7:0]        bus_rd_data_q
);

	port_vec_type  latch;
	port_vec_type  out_d;
	port_vec_type  oe_n_d;
	bus_phase_type phase;
	logic          force_addr_data;

	function automatic logic [7:0] port_mask(input logic [2:0] sel);
		port_mask = (sel == `NIBBLE_IX) ? `NIBBLE_MASK : `ALL_ONES;
	endfunction : port_mask

	always_comb
	begin
		if (!bus.active)
			phase = BUS_IDLE;
		else if (bus.drive)
			phase = BUS_DRIVE;
		else
			phase = BUS_READ;
	end

	assign force_addr_data = (phase == BUS_READ) || (phase == BUS_DRIVE);

	port_latch_bank u_latch_bank (
		.ref_clk         (ref_clk),
		.nrst            (nrst),
		.req             (req),
		.force_addr_data (force_addr_data),
		.latch_q         (latch)
	);

	always_comb
	begin
		for (int i = 1; i < `PORT_COUNT; i++)
		begin
			out_d[i]  = latch[i];
			oe_n_d[i] = latch[i];
		end
		out_d[`NIBBLE_IX]  = latch[`NIBBLE_IX] & `NIBBLE_MASK;
		oe_n_d[`NIBBLE_IX] = latch[`NIBBLE_IX] | ~`NIBBLE_MASK;
		out_d[`ADDR_DATA_IX]  = `ALL_ZEROS;
		oe_n_d[`ADDR_DATA_IX] = latch[`ADDR_DATA_IX];
		unique case (phase)
			BUS_IDLE:
			begin
				out_d[`ADDR_DATA_IX]  = `ALL_ZEROS;
			end
			BUS_DRIVE:
			begin
				out_d[`ADDR_DATA_IX]  = bus.low_ad;
				oe_n_d[`ADDR_DATA_IX] = external_access_select
					? `ALL_ZEROS : bus.low_ad;
				out_d[`HIGH_ADDR_IX]  = bus.high_address_byte;
				oe_n_d[`HIGH_ADDR_IX] = bus.high_address_byte;
			end
			BUS_READ:
			begin
				oe_n_d[`ADDR_DATA_IX] = `ALL_ONES;
				out_d[`HIGH_ADDR_IX]  = bus.high_address_byte;
				oe_n_d[`HIGH_ADDR_IX] = bus.high_address_byte;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_out_q  <= {`PORT_COUNT{`ALL_ONES}};
			pin_oe_n_q <= {`PORT_COUNT{`ALL_ONES}};
		end
		else
		begin
			pin_out_q  <= out_d;
			pin_oe_n_q <= oe_n_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			addr_data_pullup_q <= 1'b0;
		else
			addr_data_pullup_q <= (phase == BUS_DRIVE) &&
				external_access_select;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_data_q  <= `ALL_ZEROS;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= req.rd;
			if (req.rd && req.pin_read)
				rd_data_q <= pin_in[req.sel] & port_mask(req.sel);
			else if (req.rd)
				rd_data_q <= latch[req.sel] & port_mask(req.sel);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			bus_rd_data_q <= `ALL_ZEROS;
		else if (phase == BUS_READ)
			bus_rd_data_q <= pin_in[`ADDR_DATA_IX];
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_quasi_follow_latch: assert property (
		1'b1 |=> pin_oe_n_q[1] == $past(latch[1]) &&
			pin_out_q[1] == $past(latch[1]))
		else $error("port one stage does not follow latch");

	chk_addr_data_float: assert property (
		!bus.active |=> pin_oe_n_q[0] == $past(latch[0]) &&
			pin_out_q[0] == `ALL_ZEROS && !addr_data_pullup_q)
		else $error("port zero not open drain as plain I/O");

	chk_pullup_only_bus: assert property (
		addr_data_pullup_q |-> $past(bus.active && bus.drive &&
			external_access_select))
		else $error("active pull-up outside external bus drive");

	chk_high_addr_out: assert property (
		bus.active |=> pin_out_q[2] == $past(bus.high_address_byte))
		else $error("high address byte not on port two");

	chk_latch_back_after: assert property (
		bus.active ##1 !bus.active |=> pin_out_q[2] == $past(latch[2]))
		else $error("port two not back under latch control");

	chk_bus_read_release: assert property (
		bus.active && !bus.drive |=> pin_oe_n_q[0] == `ALL_ONES &&
			latch[0] == `ALL_ONES)
		else $error("port zero not released during bus read");

	chk_pin_read_path: assert property (
		req.rd && req.pin_read |=> rd_valid_q &&
			rd_data_q == ($past(pin_in[req.sel]) & port_mask($past(req.sel))))
		else $error("pin read returned wrong value");

endmodule : quasi_bidir_port_set

// ---- shared/port_defines.svh ----
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

`define PORT_COUNT   5
`define PORT_WIDTH   8
`define SEL_WIDTH    3
`define ADDR_DATA_IX 3'h0
`define HIGH_ADDR_IX 3'h2
`define NIBBLE_IX    3'h4
`define ALL_ONES     8'hFF
`define ALL_ZEROS    8'h00
`define NIBBLE_MASK  8'h0F

`endif

// ---- shared/port_pkg.sv ----
package port_pkg;

	// One byte per port, index 0 is the address/data port
	typedef logic [4:0][7:0] port_vec_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       pin_read;
		logic [2:0] sel;
		logic [7:0] data;
	} core_req_type;

	typedef struct packed {
		logic       active;
		logic       drive;
		logic [7:0] low_ad;
		logic [7:0] high_address_byte;
	} ext_bus_type;

	typedef enum logic [1:0] {
		BUS_IDLE  = 2'b00,
		BUS_DRIVE = 2'b01,
		BUS_READ  = 2'b11
	} bus_phase_type;

endpackage : port_pkg

// ---- design/port_latch_bank.sv ----
`timescale 1ns/1ps
`include "port_defines.svh"

module port_latch_bank
	import port_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire core_req_type req,
	input  wire logic         force_addr_data,
	output port_vec_type      latch_q
);

	logic first_q;

	genvar gi;
	generate
		for (gi = 0; gi < `PORT_COUNT; gi++)
		begin : g_latch
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					latch_q[gi] <= `ALL_ONES;
				else if (gi == `ADDR_DATA_IX && force_addr_data)
					latch_q[gi] <= `ALL_ONES;
				else if (req.wr && req.sel == `SEL_WIDTH'(gi))
					latch_q[gi] <= (gi == `PORT_COUNT - 1)
						? (req.data | ~`NIBBLE_MASK) : req.data;
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_reset_all_ones: assert property (
		first_q |-> latch_q == {`PORT_COUNT{`ALL_ONES}})
		else $error("latches not all ones after reset");

	chk_latch_write_one: assert property (
		req.wr && req.sel == `SEL_WIDTH'(1) |=> latch_q[1] == $past(req.data))
		else $error("port one latch missed a write");

	chk_force_addr_ones: assert property (
		force_addr_data |=> latch_q[0] == `ALL_ONES)
		else $error("address/data latch not forced high");

	chk_high_addr_kept: assert property (
		force_addr_data && !(req.wr && req.sel == `HIGH_ADDR_IX)
		|=> $stable(latch_q[2]))
		else $error("high address latch changed during bus use");

endmodule : port_latch_bank

// ---- tb/pin_load_model.sv ----
`timescale 1ns/1ps
module pin_load_model
	import port_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire port_vec_type pin_out_q,
	input  wire port_vec_type pin_oe_n_q,
	input  wire logic         ext_en,
	input  wire port_vec_type ext_val,
	output port_vec_type      pin_in
);
	logic float_q = 1'b0;

	// Floating lines change every cycle
	always @(posedge ref_clk)
		float_q <= ~float_q;

	// A driven line wins, then the outside driver, then pull-up or float
	always_comb
		for (int p = 0; p < 5; p++)
			for (int b = 0; b < 8; b++)
				if (!pin_oe_n_q[p][b])
					pin_in[p][b] = pin_out_q[p][b];
				else if (ext_en)
					pin_in[p][b] = ext_val[p][b];
				else
					pin_in[p][b] = (p == 0) ? float_q ^ b[0] : 1'b1;
endmodule : pin_load_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
	import port_pkg::*;
	typedef struct packed {
		logic [2:0] sel;
		logic [7:0] data;
		logic [7:0] latch;
		logic [7:0] pin;
	} row_type;
	logic         ref_clk = 0;
	logic         nrst = 0;
	logic         esel = 0;
	logic         ext_en = 1;
	core_req_type req = '0;
	ext_bus_type  bus = '0;
	port_vec_type ext_val = {5{8'h7E}};
	port_vec_type pin_in;
	port_vec_type pin_out_q;
	port_vec_type pin_oe_n_q;
	logic         pullup_q;
	logic         rd_valid_q;
	logic [7:0]   rd_data_q;
	logic [7:0]   bus_rd_q;
	int           miscompares = 0;
	int           compares = 0;
	int           cycles = 0;
	// ones loaded where pins are read as inputs
	row_type rows [5] = '{'{3'h0, 8'hA5, 8'hA5, 8'h24},
		'{3'h1, 8'h00, 8'h00, 8'h00}, '{3'h2, 8'hFF, 8'hFF, 8'h7E},
		'{3'h3, 8'h3C, 8'h3C, 8'h3C}, '{3'h4, 8'hF6, 8'h06, 8'h06}};

	quasi_bidir_port_set quasi_bidir_port_set_i (.ref_clk(ref_clk),
		.nrst(nrst), .req(req), .bus(bus),
		.external_access_select(esel), .pin_in(pin_in),
		.pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
		.addr_data_pullup_q(pullup_q), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q), .bus_rd_data_q(bus_rd_q));
	pin_load_model pin_load_model_i (.ref_clk(ref_clk),
		.pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	always #2.5 ref_clk = ~ref_clk;

	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic write_port(logic [2:0] s, logic [7:0] d);
		req.wr = 1;
		req.sel = s;
		req.data = d;
		tick;
		req.wr = 0;
	endtask : write_port

	task automatic read_port(logic [2:0] s, logic pins, logic [7:0] exp);
		req.rd = 1;
		req.pin_read = pins;
		req.sel = s;
		tick;
		req.rd = 0;
		check("rd_valid", 8'h01, {7'h0, rd_valid_q});
		check("rd_data", exp, rd_data_q);
		tick;
	endtask : read_port

	task automatic give_verdict;
		$display("Compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			give_verdict;
		end
	end

	initial
	begin
		row_type r;
		logic [7:0] hi;
		logic [7:0] lo;
		repeat (10) @(posedge ref_clk);
		#1;
		nrst = 1;
		for (int p = 0; p < 5; p++)
			read_port(p[2:0], 0, p == 4 ? 8'h0F : 8'hFF);
		$display("Reset state test done");
		foreach (rows[i])
		begin
			r = rows[i];
			hi = (r.sel == 3'h4) ? 8'hF0 : 8'h00;
			lo = (r.sel == 3'h0) ? 8'h00 : r.data & ~hi;
			write_port(r.sel, r.data);
			tick;
			check("oe_n", r.data | hi, pin_oe_n_q[r.sel]);
			check("out", lo, pin_out_q[r.sel]);
			read_port(r.sel, 0, r.latch);
			read_port(r.sel, 1, r.pin);
			$display("Row %0d test done", i);
		end
		ext_en = 0;
		write_port(3'h2, 8'h12);
		tick;
		write_port(3'h0, 8'h00);
		for (int e = 0; e < 2; e++)
		begin
			esel = e[0];
			bus = '{1'b1, 1'b1, 8'hC3, 8'h7E};
			tick;
			check("pullup", {7'h0, esel}, {7'h0, pullup_q});
			check("port0 out", 8'hC3, pin_out_q[0]);
			check("port0 oe_n", esel ? 8'h00 : 8'hC3, pin_oe_n_q[0]);
			check("port2 out", 8'h7E, pin_out_q[2]);
		end
		bus.drive = 0;
		ext_en = 1;
		ext_val = {5{8'h99}};
		tick;
		tick;
		check("port0 oe_n", 8'hFF, pin_oe_n_q[0]);
		check("bus data", 8'h99, bus_rd_q);
		bus.active = 0;
		tick;
		check("port2 restored", 8'h12, pin_out_q[2]);
		read_port(3'h0, 0, 8'hFF);
		$display("Bus test done");
		nrst = 0;
		tick;
		check("oe_n in reset", 8'hFF, pin_oe_n_q[1]);
		nrst = 1;
		read_port(3'h1, 0, 8'hFF);
		$display("Second reset test done");
		give_verdict;
	end
endmodule : tb
